// >>> src/ptb_map.svh
// Register addresses, field positions, reset values of the trigger and breakpoint block
`ifndef PTB_MAP_SVH
`define PTB_MAP_SVH

// Control space addresses
`define PTB_ADDR_TRIG_B     32'h1000_3004
`define PTB_ADDR_INVERT     32'h1000_3008
`define PTB_ADDR_BREAK      32'h1000_300c
`define PTB_ADDR_COUNT_B    32'h1000_3014

// Implemented bits of each register; all others hold nothing and read zero
`define PTB_TRIG_B_MASK     32'h047f_ffff
`define PTB_INVERT_MASK     32'h007f_fffc
`define PTB_BREAK_MASK      32'h0000_0fff

// Reset values
`define PTB_TRIG_B_RESET    32'h0000_0000
`define PTB_INVERT_RESET    32'h0000_0000
`define PTB_BREAK_RESET     32'h0000_0000
`define PTB_COUNT_RESET     32'h0000_0000

// Trigger enable and inversion bit positions
`define PTB_BIT_LEVEL       0
`define PTB_BIT_ANY         1
`define PTB_EV_IC_WAIT      2
`define PTB_EV_IC_PEND      3
`define PTB_EV_IC_STREAM    4
`define PTB_EV_IC_LOOKUP    5
`define PTB_EV_DC_WAIT      6
`define PTB_EV_DC_PEND      7
`define PTB_EV_DC_STREAM    8
`define PTB_EV_DC_LOOKUP    9
`define PTB_EV_WQ_FULL      10
`define PTB_EV_MEM_BUSY     11
`define PTB_EV_LBUS_BUSY    12
`define PTB_EV_MEM_RMW      13
`define PTB_EV_PAGE_HIT     14
`define PTB_EV_PRECHARGE    15
`define PTB_EV_TRANSLATE    16
`define PTB_EV_WALK         17
`define PTB_EV_PRIV         18
`define PTB_EV_BRK_HIT      19
`define PTB_EV_PIPE_HOLD    20
`define PTB_EV_FP_HOLD      21
`define PTB_EV_FQ_HOLD      22
`define PTB_EV_TICK         26

// Breakpoint field positions
`define PTB_BRK_VE          0
`define PTB_BRK_VAS_LO      1
`define PTB_BRK_VAM_LO      3
`define PTB_BRK_TWS_LO      5
`define PTB_BRK_RE          7
`define PTB_BRK_MT_LO       8

`endif

// >>> src/ptb_pkg.sv
// Types shared by the trigger and breakpoint block
package ptb_pkg;
    typedef logic [31:0] ptb_word_type;
    typedef enum logic [1:0] {
        PTB_SRC_ICACHE = 2'h0,
        PTB_SRC_DCACHE = 2'h1,
        PTB_SRC_RSVD   = 2'h2,
        PTB_SRC_PHYS   = 2'h3
    } ptb_addr_src_type;
    typedef enum logic [1:0] {
        PTB_ACC_OFF    = 2'h0,
        PTB_ACC_READ   = 2'h1,
        PTB_ACC_WRITE  = 2'h2,
        PTB_ACC_ATOMIC = 2'h3
    } ptb_access_type;
    typedef enum logic [1:0] {
        PTB_WALK_OFF   = 2'h0,
        PTB_WALK_FETCH = 2'h1,
        PTB_WALK_DATA  = 2'h2,
        PTB_WALK_RSVD  = 2'h3
    } ptb_walk_src_type;
endpackage

// >>> src/ptb_trig_if.sv
// Carrier between event gathering and trigger combining
`timescale 1ns/1ps
`default_nettype none
interface ptb_trig_if;
    ptb_pkg::ptb_word_type events;
    ptb_pkg::ptb_word_type invert;
    ptb_pkg::ptb_word_type enables;
    logic                  incr;
    modport source (output events, output invert, output enables, input incr);
    modport comb   (input events, input invert, input enables, output incr);
endinterface
`default_nettype wire

// >>> src/ptb_trig_comb.sv
// Inverts, selects and combines events into the counter increment strobe
`timescale 1ns/1ps
`default_nettype none
`include "ptb_map.svh"
module ptb_trig_comb (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Trigger carrier
    ptb_trig_if.comb tif
);
    import ptb_pkg::*;

    ptb_word_type sel;
    ptb_word_type cond;
    logic         any_sel;
    logic         or_all;
    logic         and_all;
    logic         comb_trig;
    logic         comb_prev_q;

    // Inversion before selection, tick bit not invertible
    assign cond    = tif.events ^ (tif.invert & `PTB_INVERT_MASK);
    assign sel     = tif.enables & `PTB_TRIG_B_MASK & ~32'h0000_0003;
    assign any_sel = |sel;
    assign or_all  = |(sel & cond);
    assign and_all = any_sel && (&(~sel | cond));
    assign comb_trig = tif.enables[`PTB_BIT_ANY] ? or_all : and_all;

    // Level counts every high cycle, edge counts rising transitions
    assign tif.incr = tif.enables[`PTB_BIT_LEVEL] ? comb_trig
                                                  : (comb_trig && !comb_prev_q);

    // Previous combined value for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) comb_prev_q <= 1'b0;
        else     comb_prev_q <= comb_trig;
    end

    a_edge_single_pulse: assert property (@(posedge clk) disable iff (rst)
        (!tif.enables[`PTB_BIT_LEVEL] && $stable(tif.enables) && tif.incr) |-> !$past(tif.incr))
        else $error("edge mode produced back to back increments");
    a_level_follows: assert property (@(posedge clk) disable iff (rst)
        tif.enables[`PTB_BIT_LEVEL] |-> (tif.incr == comb_trig))
        else $error("level mode increment differs from combined trigger");
    a_or_combine: assert property (@(posedge clk) disable iff (rst)
        (tif.enables[`PTB_BIT_ANY] && tif.enables[`PTB_BIT_LEVEL] && (|(sel & cond))) |-> tif.incr)
        else $error("or combine missed an active trigger");
    c_edge_count: cover property (@(posedge clk) disable iff (rst)
        !tif.enables[`PTB_BIT_LEVEL] && tif.incr);
endmodule
`default_nettype wire

// >>> src/ptb_top.sv
// Event gathering, control registers, breakpoint decode and second counter
//
// Function
// - Level bit one means level sensitive triggers; zero means edge sensitive.
// - Combine bit one ORs enabled triggers; zero ANDs them for the strobe.
// - Reserved trigger-enable bits store nothing, read zero; software writes zero.
// - Instruction miss wait rises one cycle after detection, holds until resolved.
// - Instruction miss pending rises one cycle after detection, holds until request.
// - Instruction stream high from first returned word until the line fill ends.
// - Data miss wait and pending rise one cycle later; wait to resolve, pending to request.
// - Data stream high from first returned word until the line fill ends.
// - Write queue full is high exactly while all four buffer entries are valid.
// - Translate event follows the translation attempt input, one cycle late.
// - Tablewalk event is high for the whole of each processor walk.
// - Pipeline hold event follows the stall, one cycle late.
// - Page hit fires once per access to same page as that bank's last.
// - Precharge fires once per access flagged as a page miss before issue.
// - Float hold covers dependency or queue hold; queue hold is the full queue with a float op in the pipe.
// - Clock tick trigger is always active, so enabling it alone in level mode counts every cycle.
// - Privileged event follows the supervisor flag of the processor state.
// - Each set inversion bit inverts that event before enable and combine logic.
// - One breakpoint; enabled field compares are ANDed together or used alone.
// - Address source: 00 instruction, 01 data with write buffer, 11 physical, 10 reserved.
// - Access kind: 00 off, 01 reads on miss, 10 data write miss, 11 atomic.
// - Walk source: 00 off, 01 instruction fetch walks, 10 data walks.
// - Second 32-bit counter increments whenever the combined strobe is asserted and no write to it is made.
// - Size-kind enable additionally requires operation size and type to match.
`timescale 1ns/1ps
`default_nettype none
`include "ptb_map.svh"
module ptb_top #(
    parameter int NUM_BANKS = 4,
    parameter int PAGE_W    = 12
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Control space access
    input  wire ptb_pkg::ptb_word_type cs_addr,
    input  wire logic                  cs_wr,
    input  wire logic                  cs_rd,
    input  wire ptb_pkg::ptb_word_type cs_wdata,
    output ptb_pkg::ptb_word_type      cs_rdata,
    output logic                       cs_rvalid,
    // Cache status
    input  wire logic                  ic_miss_detect,
    input  wire logic                  ic_miss_request,
    input  wire logic                  ic_miss_resolve,
    input  wire logic                  ic_first_word,
    input  wire logic                  ic_fill_done,
    input  wire logic                  ic_lookup,
    input  wire logic                  dc_miss_detect,
    input  wire logic                  dc_miss_request,
    input  wire logic                  dc_miss_resolve,
    input  wire logic                  dc_first_word,
    input  wire logic                  dc_fill_done,
    input  wire logic                  dc_lookup,
    input  wire logic [3:0]            wq_valid,
    // Memory and local bus status
    input  wire logic                  mem_busy,
    input  wire logic                  lbus_busy,
    input  wire logic                  mem_rmw,
    input  wire logic                  mem_access,
    input  wire logic [7:0]            mem_bank,
    input  wire logic [PAGE_W-1:0]     mem_page,
    // Translation and pipeline status
    input  wire logic                  tlb_attempt,
    input  wire logic                  walk_busy,
    input  wire logic                  walk_from_fetch,
    input  wire logic                  psr_super,
    input  wire logic                  pipe_stall,
    input  wire logic                  fp_ldst_dep,
    input  wire logic                  fp_queue_full,
    input  wire logic                  fp_op_in_pipe,
    // Breakpoint operands
    input  wire logic                  bp_ic_addr_hit,
    input  wire logic                  bp_dc_addr_hit,
    input  wire logic                  bp_pa_hit,
    input  wire logic                  op_read_miss,
    input  wire logic                  op_write_miss,
    input  wire logic                  op_atomic,
    input  wire logic [3:0]            op_size_kind,
    // Results
    output logic                       breakpoint_hit,
    output ptb_pkg::ptb_word_type      count_b
);
    import ptb_pkg::*;

    localparam int BANK_W = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;

    // Refuse bank counts beyond the bank index and empty page fields
    if (NUM_BANKS < 1 || NUM_BANKS > 256 || PAGE_W < 1) begin : g_bad_params
        $error("ptb_top: unsupported bank count or page width");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    ptb_word_type trig_b_q;
    ptb_word_type invert_q;
    ptb_word_type break_q;
    ptb_word_type count_q;
    ptb_word_type rdata_q;
    logic         rvalid_q;
    ptb_word_type rdata_d;
    logic         wr_trig, wr_inv, wr_brk, wr_cnt;

    ptb_trig_if tif ();

    // Address decode
    assign wr_trig = cs_wr && (cs_addr == `PTB_ADDR_TRIG_B);
    assign wr_inv  = cs_wr && (cs_addr == `PTB_ADDR_INVERT);
    assign wr_brk  = cs_wr && (cs_addr == `PTB_ADDR_BREAK);
    assign wr_cnt  = cs_wr && (cs_addr == `PTB_ADDR_COUNT_B);

    // Read select, unmapped addresses read zero
    assign rdata_d = (cs_addr == `PTB_ADDR_TRIG_B)  ? trig_b_q :
                     (cs_addr == `PTB_ADDR_INVERT)  ? invert_q :
                     (cs_addr == `PTB_ADDR_BREAK)   ? break_q  :
                     (cs_addr == `PTB_ADDR_COUNT_B) ? count_q  : 32'h0000_0000;

    // Control registers keep only implemented bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_b_q <= `PTB_TRIG_B_RESET;
            invert_q <= `PTB_INVERT_RESET;
            break_q  <= `PTB_BREAK_RESET;
        end else begin
            if (wr_trig) trig_b_q <= cs_wdata & `PTB_TRIG_B_MASK;
            if (wr_inv)  invert_q <= cs_wdata & `PTB_INVERT_MASK;
            if (wr_brk)  break_q  <= cs_wdata & `PTB_BREAK_MASK;
        end
    end

    // Second counter, a software write wins over an increment
    always_ff @(posedge clk or posedge rst) begin
        if (rst)           count_q <= `PTB_COUNT_RESET;
        else if (wr_cnt)   count_q <= cs_wdata;
        else if (tif.incr) count_q <= count_q + 32'h0000_0001;
    end

    // Read data registered, valid one cycle after the read strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q  <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cs_rd;
            if (cs_rd) rdata_q <= rdata_d;
        end
    end

    assign cs_rdata  = rdata_q;
    assign cs_rvalid = rvalid_q;
    assign count_b   = count_q;

    ////////////////////////////////////////////////////////////////////////////
    // Cache miss and stream events

    logic ic_wait_q, ic_pend_q, ic_stream_q;
    logic dc_wait_q, dc_pend_q, dc_stream_q;

    // Miss flags rise the cycle after detection; stream flags on first word
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ic_wait_q   <= 1'b0;
            ic_pend_q   <= 1'b0;
            ic_stream_q <= 1'b0;
            dc_wait_q   <= 1'b0;
            dc_pend_q   <= 1'b0;
            dc_stream_q <= 1'b0;
        end else begin
            ic_wait_q   <= ic_miss_detect || (ic_wait_q && !ic_miss_resolve);
            ic_pend_q   <= ic_miss_detect || (ic_pend_q && !ic_miss_request);
            ic_stream_q <= ic_first_word || (ic_stream_q && !ic_fill_done);
            dc_wait_q   <= dc_miss_detect || (dc_wait_q && !dc_miss_resolve);
            dc_pend_q   <= dc_miss_detect || (dc_pend_q && !dc_miss_request);
            dc_stream_q <= dc_first_word || (dc_stream_q && !dc_fill_done);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory, translation and pipeline events

    logic                 xlate_q, hold_q, page_hit, precharge;
    logic                 wq_full, fq_hold, fp_hold;
    logic [BANK_W-1:0]    bank_idx;
    logic [PAGE_W-1:0]    last_page_q [NUM_BANKS];
    logic [NUM_BANKS-1:0] page_valid_q;

    // Page match against the last page opened in this bank
    assign bank_idx  = mem_bank[BANK_W-1:0];
    assign page_hit  = mem_access && page_valid_q[bank_idx]
                       && (last_page_q[bank_idx] == mem_page);
    assign precharge = mem_access && !page_hit;
    assign wq_full   = &wq_valid;
    assign fq_hold   = fp_queue_full && fp_op_in_pipe;
    assign fp_hold   = fp_ldst_dep || fq_hold;

    // Per-bank open page tracking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_valid_q <= '0;
            for (int i = 0; i < NUM_BANKS; i++) last_page_q[i] <= '0;
        end else if (mem_access) begin
            page_valid_q[bank_idx] <= 1'b1;
            last_page_q[bank_idx]  <= mem_page;
        end
    end

    // Translation pulse and delayed stall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xlate_q <= 1'b0;
            hold_q  <= 1'b0;
        end else begin
            xlate_q <= tlb_attempt;
            hold_q  <= pipe_stall;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Breakpoint decode

    ptb_addr_src_type addr_src;
    ptb_access_type   acc_kind;
    ptb_walk_src_type walk_src;
    logic             addr_ok, acc_ok, walk_ok, size_ok;
    logic             any_field, brk_match, brk_q;

    assign addr_src = ptb_addr_src_type'(break_q[`PTB_BRK_VAS_LO +: 2]);
    assign acc_kind = ptb_access_type'(break_q[`PTB_BRK_VAM_LO +: 2]);
    assign walk_src = ptb_walk_src_type'(break_q[`PTB_BRK_TWS_LO +: 2]);

    // Address compare by selected source; reserved source never matches
    assign addr_ok = !break_q[`PTB_BRK_VE] ||
                     ((addr_src == PTB_SRC_ICACHE) && bp_ic_addr_hit) ||
                     ((addr_src == PTB_SRC_DCACHE) && bp_dc_addr_hit) ||
                     ((addr_src == PTB_SRC_PHYS)   && bp_pa_hit);
    assign acc_ok  = (acc_kind == PTB_ACC_OFF) ||
                     ((acc_kind == PTB_ACC_READ)   && op_read_miss) ||
                     ((acc_kind == PTB_ACC_WRITE)  && op_write_miss) ||
                     ((acc_kind == PTB_ACC_ATOMIC) && op_atomic);
    assign walk_ok = (walk_src == PTB_WALK_OFF) ||
                     ((walk_src == PTB_WALK_FETCH) && walk_busy && walk_from_fetch) ||
                     ((walk_src == PTB_WALK_DATA)  && walk_busy && !walk_from_fetch);
    assign size_ok = !break_q[`PTB_BRK_RE] ||
                     (op_size_kind == break_q[`PTB_BRK_MT_LO +: 4]);
    assign any_field = break_q[`PTB_BRK_VE] || (acc_kind != PTB_ACC_OFF)
                       || (walk_src != PTB_WALK_OFF) || break_q[`PTB_BRK_RE];
    assign brk_match = any_field && addr_ok && acc_ok && walk_ok && size_ok;

    // Registered hit indication
    always_ff @(posedge clk or posedge rst) begin
        if (rst) brk_q <= 1'b0;
        else     brk_q <= brk_match;
    end

    assign breakpoint_hit = brk_q;

    ////////////////////////////////////////////////////////////////////////////
    // Event vector and trigger combining

    always_comb begin
        tif.events = 32'h0000_0000;
        tif.events[`PTB_EV_IC_WAIT]   = ic_wait_q;
        tif.events[`PTB_EV_IC_PEND]   = ic_pend_q;
        tif.events[`PTB_EV_IC_STREAM] = ic_stream_q;
        tif.events[`PTB_EV_IC_LOOKUP] = ic_lookup;
        tif.events[`PTB_EV_DC_WAIT]   = dc_wait_q;
        tif.events[`PTB_EV_DC_PEND]   = dc_pend_q;
        tif.events[`PTB_EV_DC_STREAM] = dc_stream_q;
        tif.events[`PTB_EV_DC_LOOKUP] = dc_lookup;
        tif.events[`PTB_EV_WQ_FULL]   = wq_full;
        tif.events[`PTB_EV_MEM_BUSY]  = mem_busy;
        tif.events[`PTB_EV_LBUS_BUSY] = lbus_busy;
        tif.events[`PTB_EV_MEM_RMW]   = mem_rmw;
        tif.events[`PTB_EV_PAGE_HIT]  = page_hit;
        tif.events[`PTB_EV_PRECHARGE] = precharge;
        tif.events[`PTB_EV_TRANSLATE] = xlate_q;
        tif.events[`PTB_EV_WALK]      = walk_busy;
        tif.events[`PTB_EV_PRIV]      = psr_super;
        tif.events[`PTB_EV_BRK_HIT]   = brk_q;
        tif.events[`PTB_EV_PIPE_HOLD] = hold_q;
        tif.events[`PTB_EV_FP_HOLD]   = fp_hold;
        tif.events[`PTB_EV_FQ_HOLD]   = fq_hold;
        tif.events[`PTB_EV_TICK]      = 1'b1;
    end

    assign tif.invert  = invert_q;
    assign tif.enables = trig_b_q;

    ptb_trig_comb u_comb (
        .clk (clk),
        .rst (rst),
        .tif (tif.comb)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_ic_wait_rise: assert property (@(posedge clk) disable iff (rst)
        ic_miss_detect |=> ic_wait_q)
        else $error("instruction wait did not rise after miss");
    a_ic_pend_drop: assert property (@(posedge clk) disable iff (rst)
        (ic_miss_request && !ic_miss_detect) |=> !ic_pend_q)
        else $error("instruction pending held past request");
    a_dc_wait_hold: assert property (@(posedge clk) disable iff (rst)
        (dc_wait_q && !dc_miss_resolve) |=> dc_wait_q)
        else $error("data wait dropped before resolve");
    a_wq_full_exact: assert property (@(posedge clk) disable iff (rst)
        tif.events[`PTB_EV_WQ_FULL] == (wq_valid == 4'hf))
        else $error("write queue full event mismatch");
    a_pipe_delay: assert property (@(posedge clk) disable iff (rst)
        pipe_stall |=> tif.events[`PTB_EV_PIPE_HOLD])
        else $error("pipeline hold not one cycle after stall");
    a_count_step: assert property (@(posedge clk) disable iff (rst)
        (tif.incr && !wr_cnt) |=> (count_q == $past(count_q) + 32'h0000_0001))
        else $error("counter did not advance on strobe");
    a_tick_level: assert property (@(posedge clk) disable iff (rst)
        (trig_b_q == 32'h0400_0001) |-> tif.incr)
        else $error("tick trigger in level mode missed a cycle");
    a_rsvd_zero: assert property (@(posedge clk) disable iff (rst)
        (trig_b_q & ~`PTB_TRIG_B_MASK) == 32'h0000_0000)
        else $error("reserved trigger bits hold storage");
    a_brk_hit: assert property (@(posedge clk) disable iff (rst)
        (break_q[2:0] == 3'h7 && bp_pa_hit && acc_ok && walk_ok && size_ok) |=> breakpoint_hit)
        else $error("physical address breakpoint missed");
    c_breakpoint: cover property (@(posedge clk) disable iff (rst) breakpoint_hit);
    c_and_count: cover property (@(posedge clk) disable iff (rst)
        !trig_b_q[`PTB_BIT_ANY] && tif.incr);
    c_page_hit: cover property (@(posedge clk) disable iff (rst) page_hit);
endmodule
`default_nettype wire

// >>> tb/ptb_top_bench.sv
// Self-checking bench for the trigger and breakpoint block
`timescale 1ns/1ps
`default_nettype none
`include "ptb_map.svh"
module ptb_top_bench;
    import ptb_pkg::*;
    logic         clk;
    logic         rst = 1'b1;
    logic         cs_wr = 1'b0;
    logic         cs_rd = 1'b0;
    logic         wff = 1'b0;
    logic         cs_rvalid, breakpoint_hit;
    logic [3:0]   sk = 4'h0;
    logic [5:0]   bv = 6'h00;
    logic [9:0]   pp = 10'h000;
    logic [13:0]  lv = 14'h0000;
    logic [11:0]  pg = 12'h000;
    ptb_word_type cs_addr = 32'h0;
    ptb_word_type cs_wdata = 32'h0;
    ptb_word_type cs_rdata, count_b, c0;
    int           num_errors = 0;
    int           samples_checked = 0;
    int           cyc = 0;

    ptb_top u_dut (
        .clk, .rst, .cs_addr, .cs_wr, .cs_rd, .cs_wdata, .cs_rdata, .cs_rvalid,
        .ic_miss_detect(pp[0]), .ic_miss_request(pp[1]), .ic_miss_resolve(pp[2]),
        .ic_first_word(pp[3]), .ic_fill_done(pp[4]), .ic_lookup(lv[1]),
        .dc_miss_detect(pp[5]), .dc_miss_request(pp[6]), .dc_miss_resolve(pp[7]),
        .dc_first_word(pp[8]), .dc_fill_done(pp[9]), .dc_lookup(lv[2]),
        .wq_valid({4{lv[9]}}), .mem_busy(lv[3]), .lbus_busy(lv[4]), .mem_rmw(lv[5]),
        .mem_access(lv[12] | lv[13]), .mem_bank(8'h00), .mem_page(pg),
        .tlb_attempt(lv[11]), .walk_busy(lv[6]), .walk_from_fetch(wff),
        .psr_super(lv[7]), .pipe_stall(lv[8]), .fp_ldst_dep(lv[0]),
        .fp_queue_full(lv[10]), .fp_op_in_pipe(lv[10]), .bp_ic_addr_hit(bv[0]),
        .bp_dc_addr_hit(bv[1]), .bp_pa_hit(bv[2]), .op_read_miss(bv[3]),
        .op_write_miss(bv[4]), .op_atomic(bv[5]), .op_size_kind(sk), .breakpoint_hit,
        .count_b
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access and check tasks; every task starts and ends just after a falling edge
    task automatic chk(string n, ptb_word_type g, ptb_word_type e);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(ptb_word_type a, ptb_word_type d);
        cs_addr = a;
        cs_wdata = d;
        cs_wr = 1'b1;
        @(negedge clk);
        cs_wr = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(ptb_word_type a, ptb_word_type e);
        cs_addr = a;
        cs_rd = 1'b1;
        @(negedge clk);
        cs_rd = 1'b0;
        chk("rvalid", {31'h0, cs_rvalid}, 32'h1);
        chk("rdata", cs_rdata, e);
        @(negedge clk);
        chk("rvalid low", {31'h0, cs_rvalid}, 32'h0);
    endtask
    // Counter growth over a window with level inputs held for h cycles
    task automatic tst(ptb_word_type t, logic [13:0] v, int h, ptb_word_type e);
        wr(`PTB_ADDR_TRIG_B, t);
        c0 = count_b;
        lv = v;
        repeat (h) @(negedge clk);
        lv = '0;
        repeat (3) @(negedge clk);
        chk("count", count_b - c0, e);
    endtask
    // Start pulse, end pulse three cycles later, then clear every pending miss
    task automatic pl(int b, int s, int e);
        wr(`PTB_ADDR_TRIG_B, 32'h3 | (32'h1 << b));
        c0 = count_b;
        pp[s] = 1'b1;
        @(negedge clk);
        pp = '0;
        repeat (2) @(negedge clk);
        pp[e] = 1'b1;
        @(negedge clk);
        pp = '0;
        repeat (3) @(negedge clk);
        chk("pulse count", count_b - c0, 32'h3);
        pp = 10'h0c6;
        @(negedge clk);
        pp = '0;
    endtask
    task automatic bp(ptb_word_type w, logic [5:0] v, logic x);
        bv = v;
        wr(`PTB_ADDR_BREAK, w);
        @(negedge clk);
        chk("hit", {31'h0, breakpoint_hit}, {31'h0, x});
    endtask
    // One event enabled in level OR mode, its source held for five cycles
    task automatic ev(int b, int i, ptb_word_type e);
        tst(32'h3 | (32'h1 << b), 14'h1 << i, 5, e);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        ptb_word_type ra [3] = '{`PTB_ADDR_TRIG_B, `PTB_ADDR_INVERT, `PTB_ADDR_BREAK};
        ptb_word_type rm [3] = '{`PTB_TRIG_B_MASK, `PTB_INVERT_MASK, `PTB_BREAK_MASK};
        logic [5:0]   vm [4] = '{6'h01, 6'h02, 6'h07, 6'h04};
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        foreach (ra[i]) rd(ra[i], 32'h0);
        foreach (ra[i]) wr(ra[i], 32'hffff_ffff);
        foreach (ra[i]) rd(ra[i], rm[i]);
        foreach (ra[i]) wr(ra[i], 32'h0);
        rd(32'h1000_3010, 32'h0);
        wr(`PTB_ADDR_COUNT_B, 32'h0000_1234);
        rd(`PTB_ADDR_COUNT_B, 32'h0000_1234);
        tst(32'h0400_0001, '0, 4, 32'h7);
        ev(21, 0, 32'h5);
        ev(5, 1, 32'h5);
        ev(9, 2, 32'h5);
        ev(11, 3, 32'h5);
        ev(12, 4, 32'h5);
        ev(13, 5, 32'h5);
        ev(17, 6, 32'h5);
        ev(18, 7, 32'h5);
        ev(20, 8, 32'h5);
        ev(10, 9, 32'h5);
        ev(22, 10, 32'h5);
        ev(16, 11, 32'h5);
        ev(15, 12, 32'h1);
        ev(14, 13, 32'h5);
        ev(22, 0, 32'h0);
        pg = 12'h5a5;
        ev(15, 12, 32'h1);
        tst(32'h2 | (32'h1 << 11), 14'h8, 5, 32'h1);
        tst(32'h1 | (32'h1 << 11) | (32'h1 << 18), 14'h8, 5, 32'h0);
        tst(32'h1 | (32'h1 << 11) | (32'h1 << 18), 14'h88, 5, 32'h5);
        wr(`PTB_ADDR_INVERT, 32'h1 << 11);
        tst(32'h3 | (32'h1 << 11), '0, 4, 32'h7);
        wr(`PTB_ADDR_INVERT, 32'h0);
        pl(3, 0, 1);
        pl(2, 0, 2);
        pl(4, 3, 4);
        pl(7, 5, 6);
        pl(6, 5, 7);
        pl(8, 8, 9);
        foreach (vm[i]) bp(32'h1 | (ptb_word_type'(i) << 1), vm[i], i != 2);
        foreach (vm[i]) bp(ptb_word_type'(i) << 3, 6'h4 << i, i != 0);
        bp(32'h13, 6'h02, 1'b0);
        bp(32'h13, 6'h12, 1'b1);
        lv = 14'h40;
        bp(32'h20, '0, 1'b0);
        bp(32'h40, '0, 1'b1);
        wff = 1'b1;
        bp(32'h20, '0, 1'b1);
        lv = '0;
        sk = 4'h9;
        bp(32'ha88, 6'h08, 1'b0);
        bp(32'h988, 6'h08, 1'b1);
        tst(32'h3 | (32'h1 << 19), '0, 4, 32'h7);
        summarize();
    end
endmodule
`default_nettype wire
